// [src/dsm_pkg.sv]
// shared constants, field layouts and types of the multiply-add datapath
package dsm_pkg;

  // ****************************************************************
  // register map and reset values
  // ****************************************************************
  localparam logic [7:0]  ADR_CFG0 = 8'h00;         // configuration, half block 0
  localparam logic [7:0]  ADR_CFG1 = 8'h04;         // configuration, half block 1
  localparam logic [7:0]  ADR_STAT = 8'h08;         // overflow status, both halves
  localparam logic [31:0] CFG_RST  = 32'h0000_0000; // 9 bit, signs from the SIGN_A/SIGN_B ports, no pipe, no out reg
  localparam logic [31:0] STAT_RST = 32'h0000_0000;

  // ****************************************************************
  // datapath widths
  // ****************************************************************
  localparam int OP_W  = 18; // native operand width of one multiplier
  localparam int ACC_W = 44; // second-stage adder and bank width
  localparam int RES_W = 72; // joined banks for the 36 x 36 product
  localparam int HI_W  = 28; // part of the 72 bit result held in the second bank

  // ****************************************************************
  // configuration codes
  // ****************************************************************
  typedef enum logic [1:0] {
    W9  = 2'h0,
    W12 = 2'h1,
    W18 = 2'h2,
    W36 = 2'h3
  } dsm_width_t;

  typedef enum logic [1:0] {
    SS_SUM4  = 2'h0,
    SS_ACC   = 2'h1,
    SS_CHAIN = 2'h2,
    SS_NONE  = 2'h3
  } dsm_ss_t;

  typedef enum logic [1:0] {
    RS_MULT = 2'h0,
    RS_FS   = 2'h1,
    RS_PIPE = 2'h2,
    RS_SS   = 2'h3
  } dsm_rs_t;

  typedef enum logic [2:0] {
    OS_MULT = 3'h0,
    OS_FS   = 3'h1,
    OS_PIPE = 3'h2,
    OS_SS   = 3'h3,
    OS_RS   = 3'h4
  } dsm_os_t;

  // configuration word of one half block, bit 0 is width[0]
  typedef struct packed {
    logic [3:0] rsvd;       // 31:28 read as zero
    logic [1:0] ena_sel;    // 27:26 which enable line drives this half
    logic [5:0] sat_bits;   // 25:20 saturation width, 0 means 44
    logic [5:0] rnd_pos;    // 19:14 lsbs dropped by rounding
    logic       shift_mode; // 13 output select taken from the dynamic port
    logic       oreg_use;   // 12 RESULT read from the output bank, which loads either way
    dsm_os_t    out_sel;    // 11:9
    dsm_rs_t    rs_src;     // 8:7
    dsm_ss_t    ss_mode;    // 6:5
    logic       pipe_use;   // 4
    logic       fs1_sub;    // 3 first-stage adder 1 subtracts
    logic       fs0_sub;    // 2 first-stage adder 0 subtracts
    dsm_width_t width;      // 1:0
  } dsm_cfg_t;

endpackage

// [src/dsm_datapath.sv]
// two half blocks of the multiply-add-round datapath with a wishbone config port
`timescale 1ns/1ns

module dsm_datapath #(
  parameter int PIPE_CLR = 0, // clear line of the pipeline banks
  parameter int SREG_CLR = 1, // clear line of the second-adder banks
  parameter int OREG_CLR = 2  // clear line of the output banks
) (
  // clock and reset
  input  wire logic                     CLK_SYS,
  input  wire logic                     SYS_RST,
  // wishbone slave
  input  wire logic                     WB_CYC_I,
  input  wire logic                     WB_STB_I,
  input  wire logic                     WB_WE_I,
  input  wire logic [7:0]               WB_ADR_I,
  input  wire logic [3:0]               WB_SEL_I,
  input  wire logic [31:0]              WB_DAT_I,
  output logic      [31:0]              WB_DAT_O,
  output logic                          WB_ACK_O,
  // shared register controls
  input  wire logic [3:0]               ENA,
  input  wire logic [3:0]               ACLR,
  // per half operands and dynamic controls
  input  wire logic [1:0][3:0][17:0]    DATA_A,
  input  wire logic [1:0][3:0][17:0]    DATA_B,
  input  wire logic [1:0]               SIGN_A,
  input  wire logic [1:0]               SIGN_B,
  input  wire logic [1:0]               ROUND,
  input  wire logic [1:0]               SATURATE,
  input  wire logic [1:0][2:0]          OUT_SEL_DYN,
  // cascade sum
  input  wire logic [43:0]              CHAIN_IN,
  output logic      [43:0]              CHAIN_OUT,
  // results
  output logic      [1:0][71:0]         RESULT,
  output logic      [1:0]               OVERFLOW
);

  // ****************************************************************
  // arithmetic helpers
  // ****************************************************************

  // extend an operand from its native width to 19 bits, sign bit from sgn
  function automatic logic [18:0] ext_op(input logic [17:0] v,
                                         input dsm_pkg::dsm_width_t w,
                                         input logic sgn);
    logic [18:0] r;
    int          msb;
    r   = 19'h0;
    msb = (w == dsm_pkg::W9) ? 8 : (w == dsm_pkg::W12) ? 11 : 17;
    for (int i = 0; i < 19; i++) begin
      r[i] = (i <= msb) ? v[i] : (sgn & v[msb]);
    end
    return r;
  endfunction

  // 19 x 19 two's complement product, sign extended to the bank width
  function automatic logic [43:0] mul(input logic [18:0] a, input logic [18:0] b);
    logic signed [37:0] p;
    p = $signed(a) * $signed(b);
    return {{6{p[37]}}, p};
  endfunction

  // round half up at bit position pos, clearing the dropped lsbs
  function automatic logic [43:0] rnd(input logic [43:0] x, input logic [5:0] pos);
    logic [43:0] half;
    logic [43:0] mask;
    half = 44'h0;
    mask = 44'h0;
    if (pos == 6'h00 || pos > 6'h2B) begin
      return x;
    end
    half = 44'h1 << (pos - 6'h01);
    mask = ~((44'h1 << pos) - 44'h1);
    return (x + half) & mask;
  endfunction

  // clamp to a signed range of n bits; top bit flags a clamp
  function automatic logic [44:0] sat(input logic [43:0] x, input logic [5:0] n);
    logic [43:0] maxv;
    maxv = 44'h0;
    if (n == 6'h00 || n > 6'h2B) begin
      return {1'b0, x};
    end
    maxv = (44'h1 << (n - 6'h01)) - 44'h1;
    if ($signed(x) > $signed(maxv)) begin
      return {1'b1, maxv};
    end
    if ($signed(x) < $signed(~maxv)) begin
      return {1'b1, ~maxv};
    end
    return {1'b0, x};
  endfunction

  // ****************************************************************
  // wishbone register file
  // ****************************************************************
  dsm_pkg::dsm_cfg_t [1:0] cfg_ff;
  logic                    ack_ff;
  logic [31:0]             dat_ff;
  logic [1:0]              ovf_ff;
  logic                    wb_req;
  logic                    wb_wr;

  // a request is answered one edge after it is seen; ack drops the next cycle
  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign wb_wr  = wb_req & WB_WE_I;

  // byte-lane merge of a write into a config word, reserved bits forced low
  function automatic dsm_pkg::dsm_cfg_t merge(input dsm_pkg::dsm_cfg_t old,
                                              input logic [31:0] d,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    r[31:28] = 4'h0;
    return dsm_pkg::dsm_cfg_t'(r);
  endfunction

  // static configuration writes; unmapped writes are acknowledged and dropped
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cfg_ff <= {dsm_pkg::CFG_RST, dsm_pkg::CFG_RST};
    end else if (wb_wr && WB_ADR_I == dsm_pkg::ADR_CFG0) begin
      cfg_ff[0] <= merge(cfg_ff[0], WB_DAT_I, WB_SEL_I);
    end else if (wb_wr && WB_ADR_I == dsm_pkg::ADR_CFG1) begin
      cfg_ff[1] <= merge(cfg_ff[1], WB_DAT_I, WB_SEL_I);
    end
  end

  // read data and acknowledge; unmapped reads return zero
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_req;
      if (wb_req && !WB_WE_I) begin
        unique case (WB_ADR_I)
          dsm_pkg::ADR_CFG0: dat_ff <= cfg_ff[0];
          dsm_pkg::ADR_CFG1: dat_ff <= cfg_ff[1];
          dsm_pkg::ADR_STAT: dat_ff <= dsm_pkg::STAT_RST | {30'h0, ovf_ff};
          default:           dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;

  // ****************************************************************
  // half blocks
  // ****************************************************************
  logic [1:0][43:0] out_ff;
  logic [1:0][43:0] sreg_ff;
  logic [1:0][43:0] pipe0_ff;
  logic [1:0][43:0] pipe1_ff;
  logic [1:0][43:0] chain_src;

  // half 0 takes the neighbour block, half 1 takes half 0's output bank
  assign chain_src[0] = CHAIN_IN;
  assign chain_src[1] = out_ff[0];
  assign CHAIN_OUT    = out_ff[1];

  for (genvar h = 0; h < 2; h++) begin : g_half
    dsm_pkg::dsm_cfg_t cfg;
    logic [3:0][43:0]  prod;
    logic [71:0]       p72;
    logic [43:0]       fs0;
    logic [43:0]       fs1;
    logic [43:0]       post0;
    logic [43:0]       post1;
    logic [71:0]       post72;
    logic [43:0]       sum4;
    logic [43:0]       ss_comb;
    logic [43:0]       ss_out;
    logic              acc_ovf;
    logic [43:0]       rs_in;
    logic [43:0]       rounded;
    logic [44:0]       satv;
    logic [2:0]        osel;
    logic [43:0]       sel44;
    logic [71:0]       res72;
    logic              ena;
    logic [36:0]       opa36;
    logic [36:0]       opb36;
    logic [73:0]       full36;

    // each half reads only its own configuration and controls
    assign cfg = cfg_ff[h];
    assign ena = ENA[cfg.ena_sel];

    // four multipliers; inputs held low select unsigned operation
    for (genvar m = 0; m < 4; m++) begin : g_mul
      assign prod[m] = mul(ext_op(DATA_A[h][m], cfg.width, SIGN_A[h]),
                           ext_op(DATA_B[h][m], cfg.width, SIGN_B[h]));
    end

    // 36 x 36 product: both operand halves combined, formed in one multiply with no second-stage sum
    assign opa36  = {SIGN_A[h] & DATA_A[h][1][17], DATA_A[h][1], DATA_A[h][0]};
    assign opb36  = {SIGN_B[h] & DATA_B[h][1][17], DATA_B[h][1], DATA_B[h][0]};
    assign full36 = $signed(opa36) * $signed(opb36);
    assign p72    = full36[71:0];

    // first-stage adders see only products; sense fixed by configuration
    assign fs0 = cfg.fs0_sub ? prod[0] - prod[1] : prod[0] + prod[1];
    assign fs1 = cfg.fs1_sub ? prod[2] - prod[3] : prod[2] + prod[3];

    // pipeline bank; in 36 bit mode it carries the joined product instead
    always_ff @(posedge CLK_SYS or posedge ACLR[PIPE_CLR]) begin
      if (ACLR[PIPE_CLR]) begin
        pipe0_ff[h] <= 44'h0;
        pipe1_ff[h] <= 44'h0;
      end else if (SYS_RST) begin
        pipe0_ff[h] <= 44'h0;
        pipe1_ff[h] <= 44'h0;
      end else if (ena) begin
        pipe0_ff[h] <= (cfg.width == dsm_pkg::W36) ? p72[43:0] : fs0;
        pipe1_ff[h] <= (cfg.width == dsm_pkg::W36) ? {16'h0, p72[71:44]} : fs1;
      end
    end

    // bypass trades a cycle of latency against a longer path
    assign post0  = cfg.pipe_use ? pipe0_ff[h] : fs0;
    assign post1  = cfg.pipe_use ? pipe1_ff[h] : fs1;
    assign post72 = cfg.pipe_use ? {pipe1_ff[h][27:0], pipe0_ff[h]} : p72;

    // second stage: first-stage four-sum, plus the second-adder bank fed back in accumulate mode
    assign sum4    = post0 + post1;
    assign ss_comb = (cfg.ss_mode == dsm_pkg::SS_ACC) ? sreg_ff[h] + sum4 : sum4;
    assign acc_ovf = (cfg.ss_mode == dsm_pkg::SS_ACC) &&
                     (sreg_ff[h][43] == sum4[43]) && (ss_comb[43] != sum4[43]);
    // chain mode adds the registered four-sum to the cascade input
    assign ss_out  = (cfg.ss_mode == dsm_pkg::SS_CHAIN) ?
                     sreg_ff[h] + chain_src[h] : ss_comb;

    // second-adder bank; holds the upper product bits in 36 bit mode
    always_ff @(posedge CLK_SYS or posedge ACLR[SREG_CLR]) begin
      if (ACLR[SREG_CLR]) begin
        sreg_ff[h] <= 44'h0;
      end else if (SYS_RST) begin
        sreg_ff[h] <= 44'h0;
      end else if (ena) begin
        sreg_ff[h] <= (cfg.width == dsm_pkg::W36) ? {16'h0, post72[71:44]} : ss_comb;
      end
    end

    // round/sat input select, then round before saturating
    always_comb begin
      unique case (cfg.rs_src)
        dsm_pkg::RS_MULT: rs_in = prod[0];
        dsm_pkg::RS_FS:   rs_in = fs0;
        dsm_pkg::RS_PIPE: rs_in = pipe0_ff[h];
        dsm_pkg::RS_SS:   rs_in = ss_out;
      endcase
    end
    assign rounded = ROUND[h] ? rnd(rs_in, cfg.rnd_pos) : rs_in;
    assign satv    = SATURATE[h] ? sat(rounded, cfg.sat_bits) : {1'b0, rounded};

    // output select: static, or from the dynamic port in shift mode
    assign osel = cfg.shift_mode ? OUT_SEL_DYN[h] : cfg.out_sel;
    always_comb begin
      unique case (osel)
        dsm_pkg::OS_MULT: sel44 = prod[0];
        dsm_pkg::OS_FS:   sel44 = fs0;
        dsm_pkg::OS_PIPE: sel44 = pipe0_ff[h];
        dsm_pkg::OS_SS:   sel44 = ss_out;
        dsm_pkg::OS_RS:   sel44 = satv[43:0];
        default:          sel44 = 44'h0; // codes above four are unused
      endcase
    end
    assign res72 = (cfg.width == dsm_pkg::W36) ? post72 : {{28{sel44[43]}}, sel44};

    // output bank plus overflow flag
    always_ff @(posedge CLK_SYS or posedge ACLR[OREG_CLR]) begin
      if (ACLR[OREG_CLR]) begin
        out_ff[h] <= 44'h0;
        ovf_ff[h] <= 1'b0;
      end else if (SYS_RST) begin
        out_ff[h] <= 44'h0;
        ovf_ff[h] <= 1'b0;
      end else if (ena) begin
        out_ff[h] <= res72[43:0];
        ovf_ff[h] <= acc_ovf | (SATURATE[h] & satv[44]);
      end
    end

    // joined 72 bit view: upper bits from the second-adder bank in 36 bit mode
    // the bypass is combinational by design, so it carries no register
    always_comb begin
      if (!cfg.oreg_use) begin
        RESULT[h] = res72;
      end else if (cfg.width == dsm_pkg::W36) begin
        RESULT[h] = {sreg_ff[h][27:0], out_ff[h]};
      end else begin
        RESULT[h] = {{28{out_ff[h][43]}}, out_ff[h]};
      end
    end
  end

  assign OVERFLOW = ovf_ff;

endmodule

// [bench/dsm_monitor.sv]
// assertion checker on the ports of the multiply-add datapath
`timescale 1ns/1ns
module dsm_monitor #(
  parameter int OREG_CLR = 2
) (
  // clock and reset
  input wire logic                  CLK_SYS,
  input wire logic                  SYS_RST,
  // register bus
  input wire logic                  WB_CYC_I,
  input wire logic                  WB_STB_I,
  input wire logic                  WB_WE_I,
  input wire logic [7:0]            WB_ADR_I,
  input wire logic [31:0]           WB_DAT_O,
  input wire logic                  WB_ACK_O,
  // datapath
  input wire logic [3:0]            ENA,
  input wire logic [3:0]            ACLR,
  input wire logic [1:0][3:0][17:0] DATA_A,
  input wire logic [1:0][3:0][17:0] DATA_B,
  input wire logic [1:0]            SIGN_A,
  input wire logic [1:0]            SIGN_B,
  input wire logic [43:0]           CHAIN_OUT,
  input wire logic [1:0][71:0]      RESULT,
  input wire logic [1:0]            OVERFLOW
);
  // ****************
  // helpers and properties
  // ****************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  // 9 bit product of half 0, the mode that reset leaves; mod 2^72 covers both signs
  wire logic [71:0] ext_a = {{63{SIGN_A[0] & DATA_A[0][0][8]}}, DATA_A[0][0][8:0]};
  wire logic [71:0] ext_b = {{63{SIGN_B[0] & DATA_B[0][0][8]}}, DATA_B[0][0][8:0]};
  wire logic [71:0] prod9 = ext_a * ext_b;
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_quiet;
    ENA == 4'h0 && ACLR == 4'h0 && !SYS_RST;
  endsequence
  // two edges so the config clear has landed
  sequence s_in_reset;
    SYS_RST [*2];
  endsequence
  property p_ack_next;
    disable iff (SYS_RST) s_take |=> WB_ACK_O;
  endproperty
  property p_ack_pulse;
    disable iff (SYS_RST) WB_ACK_O |=> !WB_ACK_O;
  endproperty
  property p_unmapped;
    disable iff (SYS_RST) s_take ##0 (!WB_WE_I && WB_ADR_I >= 8'h0C) |=> WB_DAT_O == 32'h0;
  endproperty
  property p_stat_read;
    disable iff (SYS_RST) s_take ##0 (!WB_WE_I && WB_ADR_I == 8'h08) |=>
      WB_DAT_O == {30'h0, $past(OVERFLOW)};
  endproperty
  property p_rst_clear;
    SYS_RST |=> !WB_ACK_O && WB_DAT_O == 32'h0 && OVERFLOW == 2'h0 && CHAIN_OUT == 44'h0;
  endproperty
  property p_aclr_out;
    ACLR[OREG_CLR] |-> CHAIN_OUT == 44'h0 && OVERFLOW == 2'h0;
  endproperty
  property p_hold;
    disable iff (SYS_RST) s_quiet ##1 ACLR == 4'h0 |-> $stable(CHAIN_OUT) && $stable(OVERFLOW);
  endproperty
  property p_mult9;
    s_in_reset |-> RESULT[0] == prod9;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");
  a_rst_clear: assert property (p_rst_clear) else $error("reset left state");
  a_aclr_out: assert property (p_aclr_out) else $error("clear line ignored");
  a_hold: assert property (p_hold) else $error("bank moved with enable low");
  a_mult9: assert property (p_mult9) else $error("9 bit product wrong");
endmodule

// [bench/dsm_nbr_model.sv]
// neighbouring block model feeding the cascade sum input
`timescale 1ns/1ns
module dsm_nbr_model (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // value the neighbour's output bank loads
  input  wire logic [43:0] sum_in,
  // cascade sum towards the block
  output logic      [43:0] CHAIN_IN
);
  // the cascade leaves a registered bank, never general routing
  always_ff @(posedge CLK_SYS) begin
    CHAIN_IN <= SYS_RST ? 44'h0 : sum_in;
  end
endmodule

// [bench/tb.sv]
// self-checking testbench of the multiply-add datapath
`timescale 1ns/1ns
module tb;
  // ****************
  // signals, instances, helpers
  // ****************
  logic                  clk_sys, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]            wb_adr;
  logic [3:0]            wb_sel, ena, aclr;
  logic [31:0]           wb_wdat, wb_rdat, rd;
  logic [1:0][3:0][17:0] data_a, data_b;
  logic [1:0]            sign_a, sign_b, round, saturate, ovf;
  logic [1:0][2:0]       osel_dyn;
  logic [43:0]           nbr_sum, chain_in, chain_out;
  logic [1:0][71:0]      result;
  dsm_pkg::dsm_cfg_t     cfg;
  int                    err_total, cmp_count, cycles;

  dsm_datapath i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel),
    .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack), .ENA(ena), .ACLR(aclr),
    .DATA_A(data_a), .DATA_B(data_b), .SIGN_A(sign_a), .SIGN_B(sign_b), .ROUND(round),
    .SATURATE(saturate), .OUT_SEL_DYN(osel_dyn), .CHAIN_IN(chain_in),
    .CHAIN_OUT(chain_out), .RESULT(result), .OVERFLOW(ovf));
  dsm_nbr_model i_nbr (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .sum_in(nbr_sum),
    .CHAIN_IN(chain_in));

  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // hang guard; the run needs about a hundred cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_wdat <= d;
    do @(posedge clk_sys); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic set_cfg();
    wb(1'b1, dsm_pkg::ADR_CFG0, 4'hF, cfg);
  endtask
  // multipliers 2 and 3 repeat 0 and 1, so the four-sum is twice fs0 while fs0_sub and fs1_sub match
  task automatic ops(input logic [17:0] a0, b0, a1, b1);
    @(posedge clk_sys);
    data_a[0] <= {a1, a0, a1, a0};
    data_b[0] <= {b1, b0, b1, b0};
  endtask
  // results are settled by the falling edge
  task automatic look(input int h, input logic [71:0] e);
    @(negedge clk_sys);
    chk(result[h], e);
  endtask

  task automatic t_regs();
    wb(1'b0, dsm_pkg::ADR_CFG0, 4'hF, 32'h0);
    chk(72'(rd), 72'(dsm_pkg::CFG_RST));
    wb(1'b1, dsm_pkg::ADR_CFG1, 4'h1, 32'hF000_1234);
    wb(1'b0, dsm_pkg::ADR_CFG1, 4'hF, 32'h0);
    chk(72'(rd), 72'h34);
    wb(1'b1, dsm_pkg::ADR_CFG1, 4'hF, 32'hF000_0000);
    wb(1'b0, dsm_pkg::ADR_CFG1, 4'hF, 32'h0);
    chk(72'(rd), 72'h0);
    wb(1'b1, dsm_pkg::ADR_STAT, 4'hF, 32'h3);
    wb(1'b0, dsm_pkg::ADR_STAT, 4'hF, 32'h0);
    chk(72'(rd), 72'h0);
    wb(1'b1, 8'hFC, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'hFC, 4'hF, 32'h0);
    chk(72'(rd), 72'h0);
    $display("t_regs done");
  endtask
  task automatic t_mult();
    cfg = '0;
    cfg.width = dsm_pkg::W18;
    set_cfg();
    for (int i = 0; i < 4; i++) begin
      ops(18'h3FFFF, 18'h00002, 18'h0, 18'h0);
      sign_a <= {1'b0, i[0]};
      sign_b <= {1'b0, i[1]};
      look(0, i[0] ? 72'hFF_FFFF_FFFF_FFFF_FFFE : 72'h7FFFE);
    end
    look(1, 72'hF);
    cfg.out_sel = dsm_pkg::OS_FS;
    cfg.fs0_sub = 1'b1;
    set_cfg();
    ops(18'h00064, 18'h00005, 18'h00007, 18'h00003);
    look(0, 72'h1DF);
    cfg.fs0_sub = 1'b0;
    set_cfg();
    look(0, 72'h209);
    // shift mode takes the select from the port, held at the multiplier code
    cfg.shift_mode = 1'b1;
    set_cfg();
    look(0, 72'h1F4);
    $display("t_mult done");
  endtask
  task automatic t_pipe();
    cfg = '0;
    cfg.width = dsm_pkg::W18;
    cfg.pipe_use = 1'b1;
    cfg.oreg_use = 1'b1;
    cfg.out_sel = dsm_pkg::OS_SS;
    set_cfg();
    ops(18'h00010, 18'h00010, 18'h00001, 18'h00001);
    repeat (3) @(posedge clk_sys);
    ops(18'h00020, 18'h00010, 18'h00001, 18'h00001);
    repeat (2) look(0, 72'h202);
    look(0, 72'h402);
    @(posedge clk_sys);
    ena <= 4'h0;
    ops(18'h00010, 18'h00010, 18'h00001, 18'h00001);
    repeat (3) look(0, 72'h402);
    @(posedge clk_sys);
    aclr <= 4'h4;
    look(0, 72'h0);
    @(posedge clk_sys);
    aclr <= 4'h0;
    ena <= 4'hF;
    repeat (2) @(posedge clk_sys);
    look(0, 72'h202);
    // accumulate from a cleared second-adder bank, one four-sum per edge
    cfg.ss_mode = dsm_pkg::SS_ACC;
    cfg.pipe_use = 1'b0;
    cfg.oreg_use = 1'b0;
    set_cfg();
    @(posedge clk_sys);
    ena <= 4'h0;
    aclr <= 4'h2;
    @(posedge clk_sys);
    ena <= 4'hF;
    aclr <= 4'h0;
    // the bypassed result already holds bank plus four-sum, so the first look sees one sum
    for (int k = 0; k < 4; k++) look(0, 72'((k + 1) * 32'h202));
    $display("t_pipe done");
  endtask
  // half 0 chains from the neighbour (0x123), half 1 from half 0's output bank
  task automatic t_chain();
    cfg = '0;
    cfg.width = dsm_pkg::W18;
    cfg.ss_mode = dsm_pkg::SS_CHAIN;
    cfg.out_sel = dsm_pkg::OS_SS;
    cfg.oreg_use = 1'b1;
    set_cfg();
    cfg.width = dsm_pkg::W9;
    wb(1'b1, dsm_pkg::ADR_CFG1, 4'hF, cfg);
    repeat (3) @(posedge clk_sys);
    look(0, 72'h325);
    chk(72'(chain_out), 72'h334);
    $display("t_chain done");
  endtask
  task automatic t_round();
    cfg = '0;
    cfg.width = dsm_pkg::W18;
    cfg.rs_src = dsm_pkg::RS_MULT;
    cfg.out_sel = dsm_pkg::OS_RS;
    cfg.rnd_pos = 6'h4;
    cfg.sat_bits = 6'h8;
    set_cfg();
    ops(18'h00019, 18'h0000B, 18'h0, 18'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      round <= {1'b0, i[0]};
      saturate <= {1'b0, i[1]};
      look(0, i[1] ? 72'h7F : (i[0] ? 72'h110 : 72'h113));
    end
    // the clamp of the previous edge is registered in the overflow flag
    chk(72'(ovf), 72'h1);
    $display("t_round done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // reset with a signed 9 bit product on half 0, then the scenarios
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
    {ena, aclr} = 8'hF0;
    data_a = {54'h0, 18'h3FE05, 54'h0, 18'h001FF};
    data_b = {54'h0, 18'h00003, 54'h0, 18'h00003};
    sign_a = 2'h1;
    {sign_b, round, saturate, osel_dyn} = '0;
    nbr_sum = 44'h123;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_mult();
    t_pipe();
    t_chain();
    t_round();
    finish_test();
  end
endmodule

bind dsm_datapath dsm_monitor #(.OREG_CLR(OREG_CLR)) i_mon (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ENA(ENA), .ACLR(ACLR),
  .DATA_A(DATA_A), .DATA_B(DATA_B), .SIGN_A(SIGN_A), .SIGN_B(SIGN_B),
  .CHAIN_OUT(CHAIN_OUT), .RESULT(RESULT), .OVERFLOW(OVERFLOW));
